// File: rtl/flp_pkg.sv
package flp_pkg;

    // Opcodes of the commands this block decodes
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_PROTECT_SECTOR = 8'h36;
    localparam logic [7:0] OP_UNPROTECT_SECTOR = 8'h39;
    localparam logic [7:0] OP_OTP_PROGRAM = 8'h9b;

    // Frame layout, counted in whole bytes since chip select fell
    localparam int BCNT_W = 3;
    localparam logic [2:0] BCNT_MAX = 3'h7;
    localparam logic [2:0] IDX_OPCODE = 3'h0;
    localparam logic [2:0] IDX_STATUS_DATA = 3'h1;
    localparam logic [2:0] IDX_ADDR_LAST = 3'h3;
    localparam logic [2:0] NEED_OPCODE_ONLY = 3'h1;
    localparam logic [2:0] NEED_STATUS = 3'h2;
    localparam logic [2:0] NEED_ADDR = 3'h4;
    localparam logic [2:0] NEED_OTP_DATA = 3'h5;
    localparam int ADDR_W = 24;

    // Sector protection registers
    localparam int SECT_COUNT = 8;
    localparam int SECT_IDX_W = 3;
    localparam int SECT_ADDR_LSB = 16;
    localparam logic [7:0] SECT_ALL_PROT = 8'hff;
    localparam logic [7:0] SECT_ALL_UNPROT = 8'h00;

    // Status byte fields
    localparam int ST_LOCK = 7;
    localparam int GLOB_HI = 5;
    localparam int GLOB_LO = 2;
    localparam logic [3:0] GLOB_PROTECT = 4'hf;
    localparam logic [3:0] GLOB_UNPROTECT = 4'h0;
    localparam logic [1:0] SWP_NONE = 2'h0;
    localparam logic [1:0] SWP_SOME = 2'h1;
    localparam logic [1:0] SWP_ALL = 2'h3;

    // Security register geometry
    localparam int OTP_USER_BYTES = 64;
    localparam int OTP_ADDR_W = 6;
    localparam int OTP_RD_ADDR_W = 7;
    localparam logic [7:0] OTP_ERASED = 8'hff;
    localparam logic [5:0] OTP_IDX_STEP = 6'h01;
    // Arbitrary seed of the factory-unique half, no meaning
    localparam logic [7:0] FACTORY_SEED = 8'h5a;

    // Self-timed program duration
    localparam int SYS_CLK_MHZ = 10;
    localparam int OTP_PROG_TIME_US = 200;
    localparam int OTP_PROG_CYCLES = OTP_PROG_TIME_US * SYS_CLK_MHZ;
    localparam int TIMER_W = 12;
    localparam logic [11:0] TIMER_LOAD = 12'(OTP_PROG_CYCLES - 1);
    localparam logic [11:0] TIMER_ZERO = 12'h000;
    localparam logic [11:0] TIMER_STEP = 12'h001;

    // Link bit counter
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PROG = 3'b010,
        ST_COMMIT = 3'b100
    } flp_state_t;

endpackage : flp_pkg

// File: rtl/flp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module flp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk, // Destination clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [W-1:0] d, // Foreign-domain levels
    output logic [W-1:0] q // Synchronised levels
);

    logic [W-1:0] meta_reg;

    // Two stages; only the second stage reads the first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule : flp_sync

`default_nettype wire

// File: rtl/flp_spi_rx.sv
`timescale 1ns/1ps
`default_nettype none

module flp_spi_rx (
    input wire logic spi_sclk, // Link clock, data sampled on rise
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic spi_cs_n, // Chip select, active low
    input wire logic spi_mosi, // Serial data in
    output logic [7:0] byte_data, // Last complete byte, held
    output logic byte_tgl, // Flips once per complete byte
    output logic partial // High while a byte is only partly in
);

    logic frame_rst_n;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;

    // Chip select high clears the bit position, since sclk may be stopped then
    assign frame_rst_n = arst_n & ~spi_cs_n;

    // Bit position and shifter live only inside a frame
    always_ff @(posedge spi_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_reg <= '0;
            shift_reg <= '0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + flp_pkg::BIT_STEP;
            shift_reg <= {shift_reg[5:0], spi_mosi};
        end
    end

    // Outputs survive chip select so the system side can read them after the frame
    always_ff @(posedge spi_sclk or negedge arst_n) begin
        if (!arst_n) begin
            byte_data <= '0;
            byte_tgl <= 1'b0;
            partial <= 1'b0;
        end else begin
            partial <= (bit_cnt_reg != flp_pkg::BIT_LAST);
            if (bit_cnt_reg == flp_pkg::BIT_LAST) begin
                byte_data <= {shift_reg, spi_mosi};
                byte_tgl <= ~byte_tgl;
            end
        end
    end

endmodule : flp_spi_rx

`default_nettype wire

// File: rtl/flp_top.sv
`timescale 1ns/1ps
`default_nettype none

module flp_top (
    input wire logic sys_clk, // System clock, 10 MHz
    input wire logic arst_n, // Device reset, asynchronous, active low
    input wire logic por_n, // Initialises the nonvolatile state, active low
    input wire logic spi_sclk, // Serial clock from the host
    input wire logic spi_cs_n, // Chip select from the host, active low
    input wire logic spi_mosi, // Serial data from the host
    input wire logic wp_n, // Write-protect pin, asserted low
    input wire logic [6:0] otp_rd_addr, // Security register read location
    output logic [7:0] otp_rd_data, // Security register byte, one cycle late
    output logic [7:0] sector_prot, // One bit per sector, 1 protected
    output logic lock_bit, // Protection registers lock bit
    output logic write_enable_latch, // Write enable latch
    output logic busy, // Self-timed program in progress
    output logic hw_locked, // Hardware locking active
    output logic otp_programmed, // User area already programmed
    output logic [7:0] status_byte // Status byte as the host would read it
);

    // Link-domain byte receiver outputs
    logic [7:0] rx_byte;
    logic rx_tgl;
    logic rx_partial;

    // Synchronised copies of everything foreign except the received byte
    logic cs_s;
    logic wp_n_s;
    logic tgl_s;
    logic partial_s;

    // Edge history
    logic cs_q_reg;
    logic tgl_q_reg;
    logic frame_start;
    logic frame_end;
    logic byte_evt;

    // Frame capture
    logic [2:0] byte_cnt_reg;
    logic [7:0] opcode_reg;
    logic [23:0] addr_reg;
    logic [7:0] status_data_reg;
    logic [5:0] data_idx_reg;
    logic end_pend_reg;
    logic [7:0] buf_reg [flp_pkg::OTP_USER_BYTES];
    logic [63:0] buf_valid_reg;
    logic [5:0] buf_wr_idx;

    // Control
    flp_pkg::flp_state_t state_reg;
    logic [11:0] timer_reg;
    logic [7:0] otp_mem_reg [flp_pkg::OTP_USER_BYTES];

    // End-of-frame decode
    logic eval;
    logic aligned;
    logic locked_now;
    logic cmd_wren;
    logic cmd_wrdi;
    logic cmd_wrsr;
    logic cmd_prot;
    logic cmd_unprot;
    logic otp_cmd;
    logic otp_ok;
    logic otp_abort;
    logic [3:0] glob_field;
    logic [2:0] sect_sel;

    // Hardware locking condition, used in decode and on the output
    function automatic logic hw_lock_of(input logic wp_n_lvl, input logic lock);
        hw_lock_of = ~wp_n_lvl & lock;
    endfunction : hw_lock_of

    // Whole bytes received and no stray bits left over
    function automatic logic frame_fits(input logic [2:0] cnt, input logic [2:0] need,
                                        input logic align);
        frame_fits = align && (cnt >= need);
    endfunction : frame_fits

    // Fixed factory half; pattern is arbitrary
    function automatic logic [7:0] factory_byte(input logic [5:0] idx);
        factory_byte = flp_pkg::FACTORY_SEED ^ {2'h0, idx};
    endfunction : factory_byte

    // Serial side runs on the host's clock
    flp_spi_rx u_rx (
        .spi_sclk(spi_sclk),
        .arst_n(arst_n),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .byte_data(rx_byte),
        .byte_tgl(rx_tgl),
        .partial(rx_partial)
    );

    // Pins and link state into the system clock; the byte itself is held
    // stable for a whole byte time, so only its toggle needs syncing
    flp_sync #(
        .W(4),
        .RST_VAL(4'h3)
    ) u_sync (
        .clk(sys_clk),
        .rst_n(arst_n),
        .d({rx_partial, rx_tgl, wp_n, spi_cs_n}),
        .q({partial_s, tgl_s, wp_n_s, cs_s})
    );

    // Edge history of synchronised levels
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_q_reg <= 1'b1;
            tgl_q_reg <= 1'b0;
        end else begin
            cs_q_reg <= cs_s;
            tgl_q_reg <= tgl_s;
        end
    end

    assign frame_start = cs_q_reg & ~cs_s;
    assign frame_end = ~cs_q_reg & cs_s;
    assign byte_evt = tgl_s ^ tgl_q_reg;

    // Byte counter and header capture; saturating count is enough to tell
    // the frame classes apart
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            byte_cnt_reg <= '0;
            opcode_reg <= '0;
            addr_reg <= '0;
            status_data_reg <= '0;
        end else if (frame_start) begin
            byte_cnt_reg <= '0;
        end else if (byte_evt) begin
            if (byte_cnt_reg != flp_pkg::BCNT_MAX) begin
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
            end
            if (byte_cnt_reg == flp_pkg::IDX_OPCODE) begin
                opcode_reg <= rx_byte;
            end
            if (byte_cnt_reg == flp_pkg::IDX_STATUS_DATA) begin
                status_data_reg <= rx_byte;
            end
            if (byte_cnt_reg != flp_pkg::IDX_OPCODE && byte_cnt_reg <= flp_pkg::IDX_ADDR_LAST)
            begin
                addr_reg <= {addr_reg[15:0], rx_byte};
            end
        end
    end

    // Upper address bits never take part; start plus running index wraps at 64
    assign buf_wr_idx = addr_reg[flp_pkg::OTP_ADDR_W-1:0] + data_idx_reg;

    // Data bytes go into the shared buffer; a later byte at the same slot
    // replaces the earlier one, so a long stream leaves the final 64
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_idx_reg <= '0;
            buf_valid_reg <= '0;
        end else if (frame_start && state_reg == flp_pkg::ST_IDLE) begin
            data_idx_reg <= '0;
            buf_valid_reg <= '0;
        end else if (byte_evt && state_reg == flp_pkg::ST_IDLE &&
                     byte_cnt_reg > flp_pkg::IDX_ADDR_LAST &&
                     opcode_reg == flp_pkg::OP_OTP_PROGRAM) begin
            data_idx_reg <= data_idx_reg + flp_pkg::OTP_IDX_STEP;
            buf_valid_reg[buf_wr_idx] <= 1'b1;
        end
    end

    // Buffer storage; contents before the command are simply overwritten
    generate
        for (genvar i = 0; i < flp_pkg::OTP_USER_BYTES; i++) begin : g_buf
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    buf_reg[i] <= flp_pkg::OTP_ERASED;
                end else if (byte_evt && state_reg == flp_pkg::ST_IDLE &&
                             byte_cnt_reg > flp_pkg::IDX_ADDR_LAST &&
                             opcode_reg == flp_pkg::OP_OTP_PROGRAM &&
                             buf_wr_idx == 6'(i)) begin
                    buf_reg[i] <= rx_byte;
                end
            end
        end
    endgenerate

    // Frame end is judged one cycle after chip select rises, so a last byte
    // whose toggle synchronised in the same cycle is already counted
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            end_pend_reg <= 1'b0;
        end else begin
            end_pend_reg <= frame_end;
        end
    end

    // Frames that end while busy are ignored; only status reads are meant then
    assign eval = end_pend_reg && (state_reg == flp_pkg::ST_IDLE);
    assign aligned = ~partial_s;
    assign locked_now = hw_lock_of(wp_n_s, lock_bit);
    assign glob_field = status_data_reg[flp_pkg::GLOB_HI:flp_pkg::GLOB_LO];
    assign sect_sel = addr_reg[flp_pkg::SECT_ADDR_LSB +: flp_pkg::SECT_IDX_W];

    assign cmd_wren = eval && opcode_reg == flp_pkg::OP_WRITE_ENABLE &&
                      frame_fits(byte_cnt_reg, flp_pkg::NEED_OPCODE_ONLY, aligned);
    assign cmd_wrdi = eval && opcode_reg == flp_pkg::OP_WRITE_DISABLE &&
                      frame_fits(byte_cnt_reg, flp_pkg::NEED_OPCODE_ONLY, aligned);
    // Status writes dropped entirely under hardware lock
    assign cmd_wrsr = eval && opcode_reg == flp_pkg::OP_WRITE_STATUS && write_enable_latch &&
                      !locked_now &&
                      frame_fits(byte_cnt_reg, flp_pkg::NEED_STATUS, aligned);
    // Any set lock bit, soft or hard, refuses single-sector changes
    assign cmd_prot = eval && opcode_reg == flp_pkg::OP_PROTECT_SECTOR && write_enable_latch &&
                      !lock_bit &&
                      frame_fits(byte_cnt_reg, flp_pkg::NEED_ADDR, aligned);
    assign cmd_unprot = eval && opcode_reg == flp_pkg::OP_UNPROTECT_SECTOR &&
                        write_enable_latch && !lock_bit &&
                        frame_fits(byte_cnt_reg, flp_pkg::NEED_ADDR, aligned);

    // Program needs the latch; without it the frame is just dropped
    assign otp_cmd = eval && opcode_reg == flp_pkg::OP_OTP_PROGRAM && write_enable_latch;
    assign otp_ok = otp_cmd && !otp_programmed &&
                    frame_fits(byte_cnt_reg, flp_pkg::NEED_OTP_DATA, aligned);
    assign otp_abort = otp_cmd && !otp_ok;

    // Program sequencer: count the fixed duration, then commit
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= flp_pkg::ST_IDLE;
            timer_reg <= flp_pkg::TIMER_ZERO;
        end else begin
            case (state_reg)
                flp_pkg::ST_IDLE: begin
                    if (otp_ok) begin
                        state_reg <= flp_pkg::ST_PROG;
                        timer_reg <= flp_pkg::TIMER_LOAD;
                    end
                end
                flp_pkg::ST_PROG: begin
                    if (timer_reg == flp_pkg::TIMER_ZERO) begin
                        state_reg <= flp_pkg::ST_COMMIT;
                    end else begin
                        timer_reg <= timer_reg - flp_pkg::TIMER_STEP;
                    end
                end
                flp_pkg::ST_COMMIT: begin
                    state_reg <= flp_pkg::ST_IDLE;
                end
                default: begin
                    state_reg <= flp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Busy from the accepting cycle to the commit cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
        end else if (otp_ok) begin
            busy <= 1'b1;
        end else if (state_reg == flp_pkg::ST_COMMIT) begin
            busy <= 1'b0;
        end
    end

    // Programmed flag set at start, so a lost cycle still forbids a retry;
    // only the power-on reset clears it
    always_ff @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            otp_programmed <= 1'b0;
        end else if (otp_ok) begin
            otp_programmed <= 1'b1;
        end
    end

    // User area commit: sent bytes land at once, the rest stays erased
    generate
        for (genvar j = 0; j < flp_pkg::OTP_USER_BYTES; j++) begin : g_otp
            always_ff @(posedge sys_clk or negedge por_n) begin
                if (!por_n) begin
                    otp_mem_reg[j] <= flp_pkg::OTP_ERASED;
                end else if (state_reg == flp_pkg::ST_COMMIT && buf_valid_reg[j]) begin
                    otp_mem_reg[j] <= buf_reg[j];
                end
            end
        end
    endgenerate

    // Read port: low half user area, high half fixed factory pattern
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            otp_rd_data <= '0;
        end else if (otp_rd_addr[flp_pkg::OTP_ADDR_W]) begin
            otp_rd_data <= factory_byte(otp_rd_addr[flp_pkg::OTP_ADDR_W-1:0]);
        end else begin
            otp_rd_data <= otp_mem_reg[otp_rd_addr[flp_pkg::OTP_ADDR_W-1:0]];
        end
    end

    // Write enable latch; every program outcome leaves it clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            write_enable_latch <= 1'b0;
        end else if (otp_abort) begin
            write_enable_latch <= 1'b0;
        end else if (otp_ok) begin
            write_enable_latch <= 1'b0;
        end else if (cmd_wrsr || cmd_prot || cmd_unprot || cmd_wrdi) begin
            write_enable_latch <= 1'b0;
        end else if (cmd_wren) begin
            write_enable_latch <= 1'b1;
        end
    end

    // Lock bit is the only stored status bit; reset is the sole way out
    // while the pin is held asserted
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_bit <= 1'b0;
        end else if (cmd_wrsr) begin
            lock_bit <= status_data_reg[flp_pkg::ST_LOCK];
        end
    end

    // Sector protection; globals decode from bits 5:2 only when the lock bit
    // was clear before the write, so clearing the lock never moves them
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sector_prot <= flp_pkg::SECT_ALL_PROT;
        end else if (cmd_wrsr && !lock_bit) begin
            if (glob_field == flp_pkg::GLOB_PROTECT) begin
                sector_prot <= flp_pkg::SECT_ALL_PROT;
            end else if (glob_field == flp_pkg::GLOB_UNPROTECT) begin
                sector_prot <= flp_pkg::SECT_ALL_UNPROT;
            end
        end else if (cmd_prot) begin
            sector_prot[sect_sel] <= 1'b1;
        end else if (cmd_unprot) begin
            sector_prot[sect_sel] <= 1'b0;
        end
    end

    // Registered views; one cycle behind their sources
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hw_locked <= 1'b0;
            status_byte <= '0;
        end else begin
            hw_locked <= locked_now;
            status_byte <= {lock_bit, 2'h0, wp_n_s,
                            (sector_prot == flp_pkg::SECT_ALL_PROT) ? flp_pkg::SWP_ALL :
                            (sector_prot == flp_pkg::SECT_ALL_UNPROT) ? flp_pkg::SWP_NONE :
                            flp_pkg::SWP_SOME,
                            write_enable_latch, busy};
        end
    end

endmodule : flp_top

`default_nettype wire

// File: testbench/flp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module flp_properties (
    input wire logic sys_clk, // System clock
    input wire logic arst_n, // Device reset, active low
    input wire logic [6:0] otp_rd_addr, // Read location
    input wire logic [7:0] otp_rd_data, // Read byte
    input wire logic [7:0] sector_prot, // Sector protection
    input wire logic lock_bit, // Lock bit
    input wire logic write_enable_latch, // Write enable latch
    input wire logic busy, // Program running
    input wire logic hw_locked, // Hardware lock
    input wire logic otp_programmed, // User area used
    input wire logic [7:0] status_byte // Status byte
);
    int busy_cnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Program length is far beyond a repetition count, so count it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) busy_cnt <= 0;
        else busy_cnt <= busy ? busy_cnt + 1 : 0;
    end
    hw_lock_a: assert property (hw_locked == (!status_byte[4] && $past(lock_bit)))
        else $error("hardware lock mismatch");
    hw_frozen_a: assert property ($past(hw_locked) && hw_locked |->
        $stable(sector_prot) && $stable(lock_bit)) else $error("locked state moved");
    soft_frozen_a: assert property ($past(lock_bit) |-> $stable(sector_prot))
        else $error("soft-locked sectors moved");
    prog_accept_a: assert property ($rose(busy) |-> $past(write_enable_latch))
        else $error("program without write enable");
    prog_once_a: assert property ($rose(busy) |->
        !$past(otp_programmed) && otp_programmed) else $error("second program accepted");
    busy_wel_a: assert property (busy |-> !write_enable_latch)
        else $error("write enable set while busy");
    busy_len_a: assert property ($fell(busy) |-> busy_cnt >= 2000 && busy_cnt <= 2003)
        else $error("program time wrong");
    status_bits_a: assert property (status_byte[7] == $past(lock_bit) &&
        status_byte[1:0] == {$past(write_enable_latch), $past(busy)})
        else $error("status bits wrong");
    swp_field_a: assert property ($past(arst_n) |-> status_byte[3:2] ==
        ($past(sector_prot) == 8'hff ? 2'h3 : $past(sector_prot) == 8'h00 ? 2'h0 : 2'h1))
        else $error("swp wrong");
    fixed_half_a: assert property ($past(arst_n) && $past(otp_rd_addr) >= 7'h40 |->
        otp_rd_data == (flp_pkg::FACTORY_SEED ^ {1'b0, $past(otp_rd_addr)} ^ 8'h40))
        else $error("factory byte wrong");
endmodule : flp_properties
bind flp_top flp_properties u_props (.sys_clk, .arst_n, .otp_rd_addr, .otp_rd_data,
    .sector_prot, .lock_bit, .write_enable_latch, .busy, .hw_locked, .otp_programmed,
    .status_byte);
`default_nettype wire

// File: testbench/flp_host.sv
`timescale 1ns/1ps
`default_nettype none
module flp_host (
    output logic sclk, // Serial clock, still between frames
    output logic cs_n, // Chip select, active low
    output logic mosi // Serial data, MSB first
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // One frame in mode 0; extra stray bits make an unaligned release
    task automatic frame(input logic [7:0] q[$], input int extra);
        logic [7:0] b;
        #37 cs_n = 1'b0;
        for (int i = 0; i < q.size() * 8 + extra; i++) begin
            b = (i / 8 < q.size()) ? q[i / 8] : 8'h00;
            mosi = b[7 - i % 8];
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        mosi = ~mosi; // Released line must not keep its last level
        #900;
    endtask : frame
endmodule : flp_host
`default_nettype wire

// File: testbench/flp_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module flp_top_bench;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic por_n = 1'b0;
    logic wp_n = 1'b1;
    logic [6:0] otp_rd_addr = 7'h00;
    wire logic spi_sclk;
    wire logic spi_cs_n;
    wire logic spi_mosi;
    logic [7:0] otp_rd_data, sector_prot, status_byte;
    logic lock_bit, write_enable_latch, busy, hw_locked, otp_programmed;
    logic [7:0] q[$];
    logic [7:0] mem[64];
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int s;
    always #50 sys_clk = ~sys_clk;
    flp_top u_dut (.sys_clk, .arst_n, .por_n, .spi_sclk, .spi_cs_n, .spi_mosi, .wp_n,
        .otp_rd_addr, .otp_rd_data, .sector_prot, .lock_bit, .write_enable_latch, .busy,
        .hw_locked, .otp_programmed, .status_byte);
    flp_host u_host (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi));
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    function automatic logic [7:0] st_exp(input logic lk, input logic [7:0] sp);
        return {lk, 3'h1, (sp == 8'hff) ? 2'h3 : (sp == 8'h00) ? 2'h0 : 2'h1, 2'h0};
    endfunction : st_exp
    task automatic st(input logic [7:0] sp, input logic lk);
        chk(sector_prot, sp);
        chk(status_byte, st_exp(lk, sp));
    endtask : st
    // Por also wipes the user area, as a power cycle would
    task automatic reset_all(input logic por);
        @(negedge sys_clk);
        arst_n = 1'b0;
        por_n = ~por;
        repeat (4) @(negedge sys_clk);
        arst_n = 1'b1;
        por_n = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask : reset_all
    task automatic wr(input logic [7:0] c[$]);
        u_host.frame('{8'h06}, 0);
        u_host.frame(c, 0);
    endtask : wr
    task automatic rd(input int a, input logic [7:0] e);
        @(negedge sys_clk);
        otp_rd_addr = 7'(a);
        @(negedge sys_clk);
        chk(otp_rd_data, e);
    endtask : rd
    // Later bytes overwrite earlier ones, so only the last 64 survive
    task automatic prog(input logic [7:0] a0, input int n);
        logic [7:0] d;
        logic [7:0] ev;
        q = '{8'h9b, 8'($urandom), 8'($urandom), a0};
        for (int k = 0; k < 64; k++) mem[k] = 8'hff;
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            q.push_back(d);
            mem[(a0[5:0] + k) % 64] = d;
        end
        wr(q);
        chk({busy, write_enable_latch}, 8'h02);
        for (int i = 0; i < 2100 && busy !== 1'b0; i++) @(negedge sys_clk);
        chk(busy, 8'h00);
        for (int k = 0; k < 128; k++) begin
            ev = (k < 64) ? mem[k] : flp_pkg::FACTORY_SEED ^ 8'(k - 64);
            rd(k, ev);
        end
    endtask : prog
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        void'($urandom(2));
        reset_all(1'b1);
        st(8'hff, 1'b0);
        wr('{8'h01, 8'h00});
        st(8'h00, 1'b0);
        s = $urandom_range(7);
        wr('{8'h36, 8'(s), 8'(s), 8'h00});
        st(8'h01 << s, 1'b0);
        wr('{8'h01, 8'h7f});
        st(8'hff, 1'b0);
        wr('{8'h01, 8'h80});
        st(8'h00, 1'b1);
        wr('{8'h36, 8'(s), 8'h00, 8'h00});
        chk(sector_prot, 8'h00);
        wr('{8'h01, 8'h3c});
        st(8'h00, 1'b0);
        wr('{8'h01, 8'hbc});
        st(8'hff, 1'b1);
        @(negedge sys_clk) wp_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(hw_locked, 8'h01);
        wr('{8'h01, 8'h00});
        wr('{8'h39, 8'h00, 8'h00, 8'h00});
        chk(sector_prot, 8'hff);
        chk(lock_bit, 8'h01);
        reset_all(1'b0);
        chk({lock_bit, hw_locked}, 8'h00);
        @(negedge sys_clk) wp_n = 1'b1;
        u_host.frame('{8'h9b, 8'h00, 8'h00, 8'h00, 8'h11}, 0);
        chk({otp_programmed, busy}, 8'h00);
        wr('{8'h9b, 8'h00, 8'h00, 8'h00});
        chk({otp_programmed, write_enable_latch, busy}, 8'h00);
        u_host.frame('{8'h06}, 0);
        u_host.frame('{8'h9b, 8'h00, 8'h00, 8'h00, 8'h22}, 3);
        chk({otp_programmed, write_enable_latch}, 8'h00);
        prog(8'hfe, 3);
        reset_all(1'b1);
        prog(8'($urandom), 70);
        wr('{8'h9b, 8'h00, 8'h00, 8'h00, 8'h33});
        chk({otp_programmed, write_enable_latch, busy}, 8'h04);
        close_out();
    end
endmodule : flp_top_bench
`default_nettype wire
